// >>> src/amc_mode_clock.sv
`timescale 1ns/100ps
module amc_mode_clock (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        reset_cmd,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    input  wire logic [2:0]  chan_ready,
    input  wire logic        data_taken,
    output logic             reg_crc_check_en,
    output logic             rx_crc_check_en,
    output logic [15:0]      crc_poly,
    output logic             reset_flag,
    output logic [5:0]       word_bits,
    output logic             word_sign_ext,
    output logic             abort_en,
    output logic [2:0]       chan_convert_en,
    output logic             mod_tick,
    output logic [15:0]      osr_value,
    output logic             low_power,
    output logic             conversion_ready_pin_o,
    output logic             conversion_ready_pin_oe
);
    // ========================================
    // Registers
    logic [15:0] mode_reg, mode_next;
    logic [15:0] clock_reg, clock_next;
    logic        rflag_reg, rflag_next;
    logic [2:0]  rdy_sync1_reg, rdy_sync2_reg, rdy_prev_reg;
    logic        pend_reg, pend_next;
    logic [3:0]  pcnt_reg, pcnt_next;
    logic        pin_low;
    logic        pin_o_next;
    logic        pin_oe_next;
    logic [3:0]  div_ratio;
    logic [2:0]  en_rdy;
    logic        src_lvl, src_rise;
    logic        lag_ok;

    function automatic logic [15:0] masked_write(input logic [15:0] old,
                                                 input logic [15:0] wd,
                                                 input logic [15:0] mk);
        masked_write = (old & ~mk) | (wd & mk);
    endfunction : masked_write

    always_comb begin
        mode_next  = mode_reg;
        clock_next = clock_reg;
        rflag_next = rflag_reg;
        if (reg_wr && reg_addr == amc_pkg::MODE_ADDR) begin
            mode_next = masked_write(mode_reg, reg_wdata,
                                     amc_pkg::MODE_WMASK);
            if (!reg_wdata[amc_pkg::RST_ACK_BIT])
                rflag_next = 1'b0;
        end else if (reg_wr && reg_addr == amc_pkg::CLOCK_ADDR) begin
            clock_next = masked_write(clock_reg, reg_wdata,
                                      amc_pkg::CLOCK_WMASK);
        end
        mode_next[amc_pkg::RST_ACK_BIT] = rflag_next;
        if (reset_cmd) begin
            mode_next  = amc_pkg::MODE_RESET;
            clock_next = amc_pkg::CLOCK_RESET;
            rflag_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mode_reg  <= amc_pkg::MODE_RESET;
            clock_reg <= amc_pkg::CLOCK_RESET;
            rflag_reg <= 1'b1;
        end else begin
            mode_reg  <= mode_next;
            clock_reg <= clock_next;
            rflag_reg <= rflag_next;
        end
    end

    always_comb begin
        if (reg_addr == amc_pkg::MODE_ADDR)
            reg_rdata = mode_reg;
        else if (reg_addr == amc_pkg::CLOCK_ADDR)
            reg_rdata = clock_reg;
        else
            reg_rdata = 16'h0000;
    end

    // ========================================
    // Configuration decode
    assign reg_crc_check_en = mode_reg[amc_pkg::REG_CRC_BIT];
    assign rx_crc_check_en  = mode_reg[amc_pkg::RX_CRC_BIT];
    assign crc_poly = mode_reg[amc_pkg::CRC_POLY_BIT] ?
        amc_pkg::POLY_ANSI : amc_pkg::POLY_CCITT;
    assign reset_flag = rflag_reg;
    assign abort_en   = mode_reg[amc_pkg::ABORT_EN_BIT];
    assign chan_convert_en = clock_reg[amc_pkg::CHAN_EN_LSB +: 3];
    assign low_power = clock_reg[amc_pkg::PWR_LSB +: 2]
        == amc_pkg::PWR_LOW;

    always_comb begin
        word_sign_ext = 1'b0;
        case (mode_reg[amc_pkg::WSIZE_LSB +: 2])
            2'h0:    word_bits = amc_pkg::WBITS_16;
            2'h1:    word_bits = amc_pkg::WBITS_24;
            2'h2:    word_bits = amc_pkg::WBITS_32;
            default: begin
                word_bits     = amc_pkg::WBITS_32;
                word_sign_ext = 1'b1;
            end
        endcase
    end

    always_comb begin
        case (clock_reg[amc_pkg::CLK_DIV_LSB +: 2])
            2'h0:    div_ratio = amc_pkg::DIV_2;
            2'h1:    div_ratio = amc_pkg::DIV_4;
            2'h2:    div_ratio = amc_pkg::DIV_8;
            default: div_ratio = amc_pkg::DIV_12;
        endcase
    end

    always_comb begin
        if (clock_reg[amc_pkg::TURBO_BIT])
            osr_value = amc_pkg::OSR_TURBO;
        else
            osr_value = amc_pkg::OSR_BASE
                << clock_reg[amc_pkg::OSR_LSB +: 3];
    end

    amc_clk_div u_div (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .div_ratio (div_ratio),
        .mod_tick  (mod_tick)
    );

    // ========================================
    // Ready pin
    assign en_rdy = rdy_sync2_reg & chan_convert_en;
    // Lagging source: at least one channel enabled and every enabled channel has data
    assign lag_ok = ((rdy_sync2_reg | ~chan_convert_en) == 3'h7)
        && (chan_convert_en != 3'h0);

    always_comb begin
        case (amc_pkg::amc_src_t'(mode_reg[amc_pkg::RSRC_LSB +: 2]))
            amc_pkg::AMC_SRC_LAG: src_lvl = lag_ok;
            amc_pkg::AMC_SRC_OR:  src_lvl = |en_rdy;
            default:              src_lvl = |en_rdy;
        endcase
        case (amc_pkg::amc_src_t'(mode_reg[amc_pkg::RSRC_LSB +: 2]))
            amc_pkg::AMC_SRC_LAG: src_rise = lag_ok
                && (((rdy_prev_reg | ~chan_convert_en) != 3'h7));
            amc_pkg::AMC_SRC_OR:  src_rise = |(en_rdy & ~rdy_prev_reg);
            default:              src_rise = |en_rdy
                && !(|(rdy_prev_reg & chan_convert_en));
        endcase
    end

    // Pending state, pulse countdown and pin value
    always_comb begin
        pend_next = pend_reg;
        pcnt_next = (pcnt_reg != 4'h0) ? pcnt_reg - 4'h1 : 4'h0;
        if (data_taken)
            pend_next = 1'b0;
        if (src_rise) begin
            pend_next = 1'b1;
            pcnt_next = amc_pkg::PULSE_CYC;
        end else if (!src_lvl) begin
            pend_next = 1'b0;
        end
        if (mode_reg[amc_pkg::PULSE_FMT_BIT])
            pin_low = (pcnt_next != 4'h0);
        else
            pin_low = pend_next;
        if (pin_low) begin
            pin_o_next  = 1'b0;
            pin_oe_next = 1'b1;
        end else begin
            // Idle level or released pin
            pin_o_next  = 1'b1;
            pin_oe_next = !mode_reg[amc_pkg::FLOAT_BIT];
        end
    end

    // Two-flop synchroniser on the ready inputs
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdy_sync1_reg <= 3'h0;
            rdy_sync2_reg <= 3'h0;
            rdy_prev_reg  <= 3'h0;
            pend_reg      <= 1'b0;
            pcnt_reg      <= 4'h0;
            conversion_ready_pin_o  <= 1'b1;
            conversion_ready_pin_oe <= 1'b1;
        end else begin
            rdy_sync1_reg <= chan_ready;
            rdy_sync2_reg <= rdy_sync1_reg;
            rdy_prev_reg  <= rdy_sync2_reg;
            pend_reg      <= pend_next;
            pcnt_reg      <= pcnt_next;
            conversion_ready_pin_o  <= pin_o_next;
            conversion_ready_pin_oe <= pin_oe_next;
        end
    end
endmodule : amc_mode_clock

// >>> src/amc_pkg.sv
package amc_pkg;
    // ========================================
    // Register map
    localparam logic [7:0]  MODE_ADDR       = 8'h02;
    localparam logic [7:0]  CLOCK_ADDR      = 8'h03;
    localparam logic [15:0] MODE_RESET      = 16'h0510;
    localparam logic [15:0] CLOCK_RESET     = 16'h070E;
    localparam logic [15:0] MODE_WMASK      = 16'h3F1F;
    localparam logic [15:0] CLOCK_WMASK     = 16'h07FF;
    // ========================================
    // Mode register fields
    localparam int REG_CRC_BIT   = 13;
    localparam int RX_CRC_BIT    = 12;
    localparam int CRC_POLY_BIT  = 11;
    localparam int RST_ACK_BIT   = 10;
    localparam int WSIZE_LSB     = 8;
    localparam int ABORT_EN_BIT  = 4;
    localparam int RSRC_LSB      = 2;
    localparam int FLOAT_BIT     = 1;
    localparam int PULSE_FMT_BIT = 0;
    // ========================================
    // Clock register fields
    localparam int CHAN_EN_LSB   = 8;
    localparam int CLK_DIV_LSB   = 6;
    localparam int TURBO_BIT     = 5;
    localparam int OSR_LSB       = 2;
    localparam int PWR_LSB       = 0;
    // ========================================
    // Encodings and constants
    localparam logic [15:0] POLY_CCITT   = 16'h1021;
    localparam logic [15:0] POLY_ANSI    = 16'h8005;
    localparam logic [5:0]  WBITS_16     = 6'h10;
    localparam logic [5:0]  WBITS_24     = 6'h18;
    localparam logic [5:0]  WBITS_32     = 6'h20;
    localparam logic [15:0] OSR_TURBO    = 16'h0040;
    localparam logic [15:0] OSR_BASE     = 16'h0080;
    localparam logic [3:0]  DIV_2        = 4'h2;
    localparam logic [3:0]  DIV_4        = 4'h4;
    localparam logic [3:0]  DIV_8        = 4'h8;
    localparam logic [3:0]  DIV_12       = 4'hC;
    localparam logic [1:0]  PWR_LOW      = 2'h1;
    localparam logic [1:0]  PWR_HIGH     = 2'h2;
    localparam int          PULSE_NS     = 8;
    localparam int          CLK_NS       = 4;
    localparam logic [3:0]  PULSE_CYC    =
        4'((PULSE_NS + CLK_NS - 1) / CLK_NS);
    typedef enum logic [1:0] {
        AMC_SRC_LAG, AMC_SRC_OR, AMC_SRC_LEAD, AMC_SRC_LEAD2
    } amc_src_t;
endpackage : amc_pkg

// >>> src/amc_clk_div.sv
`timescale 1ns/100ps
// ========================================
// Modulator clock enable divider
module amc_clk_div (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic [3:0] div_ratio,
    output logic            mod_tick
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic       tick_reg;
    logic       tick_next;

    always_comb begin
        if (cnt_reg >= div_ratio - 4'h1) begin
            cnt_next  = 4'h0;
            tick_next = 1'b1;
        end else begin
            cnt_next  = cnt_reg + 4'h1;
            tick_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg  <= 4'h0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign mod_tick = tick_reg;
endmodule : amc_clk_div

// >>> verif/amc_mc_props.sv
`timescale 1ns/100ps
module amc_mc_props (
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic        reset_cmd,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_crc_check_en,
    input wire logic        rx_crc_check_en,
    input wire logic [15:0] crc_poly,
    input wire logic        reset_flag,
    input wire logic [5:0]  word_bits,
    input wire logic        word_sign_ext,
    input wire logic        abort_en,
    input wire logic [2:0]  chan_convert_en,
    input wire logic [15:0] osr_value,
    input wire logic        low_power
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic [15:0] wd_reg;
    always_ff @(posedge sys_clk) wd_reg <= reg_wdata;
    sequence mode_wr;
        reg_wr && !reset_cmd && reg_addr == amc_pkg::MODE_ADDR;
    endsequence
    sequence clk_wr;
        reg_wr && !reset_cmd && reg_addr == amc_pkg::CLOCK_ADDR;
    endsequence
    crc_enable_a : assert property (
        mode_wr |=> reg_crc_check_en == wd_reg[13]
        && rx_crc_check_en == wd_reg[12]) else $error("crc enable");
    crc_poly_a : assert property (mode_wr |=> crc_poly ==
        (wd_reg[11] ? amc_pkg::POLY_ANSI : amc_pkg::POLY_CCITT))
        else $error("crc poly");
    flag_clear_a : assert property (
        mode_wr ##0 !reg_wdata[10] |=> !reset_flag) else $error("flag");
    word_size_a : assert property (mode_wr |=>
        word_bits == (wd_reg[9:8] == 2'h0 ? 6'h10 : wd_reg[9:8] == 2'h1 ?
        6'h18 : 6'h20) && word_sign_ext == (wd_reg[9:8] == 2'h3))
        else $error("word size");
    abort_en_a : assert property (
        mode_wr |=> abort_en == wd_reg[4]) else $error("abort");
    chan_en_a : assert property (
        clk_wr |=> chan_convert_en == wd_reg[10:8]) else $error("chan");
    osr_sel_a : assert property (clk_wr |=> osr_value ==
        (wd_reg[5] ? amc_pkg::OSR_TURBO : amc_pkg::OSR_BASE << wd_reg[4:2]))
        else $error("osr");
    power_sel_a : assert property (
        clk_wr |=> low_power == (wd_reg[1:0] == 2'h1)) else $error("pwr");
    reset_cmd_a : assert property (reset_cmd |=> reset_flag
        && abort_en && chan_convert_en == 3'h7 && osr_value == 16'h0400)
        else $error("reset command");
endmodule : amc_mc_props
bind amc_mode_clock amc_mc_props amc_mc_props_i (.sys_clk, .resetn,
    .reset_cmd, .reg_wr, .reg_addr, .reg_wdata, .reg_crc_check_en,
    .rx_crc_check_en, .crc_poly, .reset_flag, .word_bits, .word_sign_ext,
    .abort_en, .chan_convert_en, .osr_value, .low_power);

// >>> verif/amc_host_model.sv
`timescale 1ns/100ps
module amc_host_model (
    input  wire logic sys_clk,
    input  wire logic pin_o,
    input  wire logic pin_oe,
    output logic      pin_level
);
    logic last_reg;
    always_ff @(posedge sys_clk) if (pin_oe) last_reg <= pin_o;
    // Released pin shows the inverse of the last driven level
    assign pin_level = pin_oe ? pin_o : ~last_reg;
endmodule : amc_host_model

// >>> verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    typedef struct packed {
        logic [7:0] a; logic [15:0] d, r, x;
    } amc_row_t;
    localparam amc_row_t ROWS [11] = '{
        '{8'h02, 16'h0110, 16'h0110, 16'h1021},
        '{8'h02, 16'h3F1F, 16'h3B1F, 16'h8005},
        '{8'h02, 16'h2204, 16'h2204, 16'h1021},
        '{8'h02, 16'h1308, 16'h1308, 16'h1021},
        '{8'h02, 16'h080C, 16'h080C, 16'h8005},
        '{8'h03, 16'h07FD, 16'h07FD, 16'h0040},
        '{8'h03, 16'h0001, 16'h0001, 16'h0080},
        '{8'h03, 16'h001D, 16'h001D, 16'h4000},
        '{8'h03, 16'h050E, 16'h050E, 16'h0400},
        '{8'h03, 16'h000A, 16'h000A, 16'h0200},
        '{8'h05, 16'h0001, 16'h0000, 16'h0200}};
    localparam int DIVS [4] = '{2, 4, 8, 12};
    logic        sys_clk, resetn, reset_cmd, reg_wr, data_taken, mod_tick;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, crc_poly, osr_value;
    logic [2:0]  chan_ready, chan_convert_en;
    logic [5:0]  word_bits;
    logic        reg_crc_check_en, rx_crc_check_en, reset_flag, abort_en;
    logic        word_sign_ext, low_power, pin_level;
    logic        conversion_ready_pin_o, conversion_ready_pin_oe;
    int          fails = 0, samples_checked = 0, ticks = 0, cyc = 0;
    amc_mode_clock amc_mode_clock_i (.sys_clk, .resetn, .reset_cmd,
        .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .chan_ready,
        .data_taken, .reg_crc_check_en, .rx_crc_check_en, .crc_poly,
        .reset_flag, .word_bits, .word_sign_ext, .abort_en,
        .chan_convert_en, .mod_tick, .osr_value, .low_power,
        .conversion_ready_pin_o, .conversion_ready_pin_oe);
    amc_host_model amc_host_model_i (.sys_clk, .pin_o(conversion_ready_pin_o),
        .pin_oe(conversion_ready_pin_oe), .pin_level);
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (mod_tick === 1'b1) ticks++;
        if (cyc == 5000) begin
            fails++;
            results();
        end
    end
    task automatic results();
        $display("samples_checked=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic pin_case(input logic [15:0] m, input logic [2:0] rdy,
                            input logic l8);
        int n; logic lo, at8;
        n = 0; at8 = 1'b0;
        wr(amc_pkg::MODE_ADDR, m);
        chan_ready = rdy;
        for (int i = 0; i < 12; i++) begin
            @(negedge sys_clk);
            lo = conversion_ready_pin_oe === 1'b1 && pin_level === 1'b0;
            n += lo;
            if (i == 8) at8 = lo;
        end
        chk(at8, l8);
        if (m[0]) chk(16'(n), 16'(amc_pkg::PULSE_CYC));
        data_taken = 1'b1;
        @(negedge sys_clk);
        data_taken = 1'b0; chan_ready = 3'h0;
        repeat (4) @(negedge sys_clk);
        chk(conversion_ready_pin_oe, !m[1]);
        chk(conversion_ready_pin_o | m[1], 1'b1);
    endtask : pin_case
    initial begin
        resetn = 1'b0; reset_cmd = 1'b0; reg_wr = 1'b0; data_taken = 1'b0;
        reg_addr = 8'h02; reg_wdata = 16'h0000; chan_ready = 3'h0;
        repeat (6) @(negedge sys_clk);
        resetn = 1'b1;
        foreach (ROWS[k]) begin
            wr(ROWS[k].a, ROWS[k].d);
            #1 chk(reg_rdata, ROWS[k].r);
            chk(ROWS[k].a == 8'h02 ? crc_poly : osr_value, ROWS[k].x);
        end
        for (int d = 0; d < 4; d++) begin
            wr(amc_pkg::CLOCK_ADDR, 16'h070E | 16'(d << 6));
            repeat (8) @(negedge sys_clk);
            ticks = 0;
            repeat (96) @(negedge sys_clk);
            chk(16'(ticks), 16'(96 / DIVS[d]));
        end
        pin_case(16'h0104, 3'h1, 1'b1);
        pin_case(16'h0100, 3'h1, 1'b0);
        pin_case(16'h0100, 3'h7, 1'b1);
        pin_case(16'h0108, 3'h2, 1'b1);
        pin_case(16'h010C, 3'h4, 1'b1);
        pin_case(16'h0106, 3'h1, 1'b1);
        pin_case(16'h0105, 3'h1, 1'b0);
        @(negedge sys_clk);
        reset_cmd = 1'b1; reg_wr = 1'b1; reg_addr = 8'h02; reg_wdata = 16'h0;
        @(negedge sys_clk);
        reset_cmd = 1'b0; reg_wr = 1'b0;
        #1 chk(reset_flag, 1'b1);
        chk(reg_rdata, amc_pkg::MODE_RESET);
        wr(amc_pkg::MODE_ADDR, 16'h0110);
        resetn = 1'b0;
        repeat (6) @(negedge sys_clk);
        resetn = 1'b1;
        #1 chk(reset_flag, 1'b1);
        chk(conversion_ready_pin_oe & conversion_ready_pin_o, 1'b1);
        @(negedge sys_clk);
        reg_addr = amc_pkg::CLOCK_ADDR;
        #1 chk(reg_rdata, amc_pkg::CLOCK_RESET);
        results();
    end
endmodule : tb_top
